// ### hdl/tmb_consts.svh
/*
  Constants of the six-channel timer block: register map, mode field codes,
  prescaler counts and counter limits.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef TMB_CONSTS_SVH
`define TMB_CONSTS_SVH

// ****************************************
// Structure
// ****************************************
`define TMB_NUM_CH      6
`define TMB_CNT_W       16
`define TMB_ADDR_W      8
`define TMB_DATA_W      32
`define TMB_CH_IDX_W    3
`define TMB_DIV_W       5

// ****************************************
// Register map
// ****************************************
`define TMB_CH_SHIFT    3
`define TMB_SEL_BIT     2
`define TMB_SEL_TIMER   1'b0
`define TMB_SEL_MODE    1'b1
`define TMB_START_ADDR  8'h30
`define TMB_ALIGN_ZERO  2'b00
`define TMB_RD_ZERO     32'h0000_0000

// ****************************************
// Mode field codes
// ****************************************
`define TMB_MODE_TIMER   2'b00
`define TMB_MODE_EVENT   2'b01
`define TMB_MODE_MEASURE 2'b10
`define TMB_MODE_RSVD    2'b11
`define TMB_EDGE_FALL    2'b00
`define TMB_EDGE_RISE    2'b01
`define TMB_EDGE_BOTH    2'b10
`define TMB_CLK_DIV1     2'b00
`define TMB_CLK_DIV8     2'b01
`define TMB_CLK_DIV32    2'b10
`define TMB_CLK_SUB32    2'b11
`define TMB_SRC_PIN      1'b0
`define TMB_SRC_CHAIN    1'b1

// ****************************************
// Counts
// ****************************************
`define TMB_CNT_ZERO     16'h0000
`define TMB_CNT_MAX      16'hFFFF
`define TMB_CNT_ONE      16'h0001
`define TMB_DIV8_MASK    5'h07
`define TMB_DIV32_LAST   5'h1F
`define TMB_DIV_ONE      5'h01

`endif

// ### hdl/tmb_pkg.sv
/*
  Types of the six-channel timer block: mode register layout, channel state,
  whole-block state and prescaler state.
  Assumes tmb_consts.svh is on the include path.
*/
`include "tmb_consts.svh"

package tmb_pkg;

  // ****************************************
  // Mode register layout, high bits first from the left
  // ****************************************
  typedef struct packed {
    logic [1:0] clk_sel;
    logic       ovf;
    logic       ev_src;
    logic [1:0] edge_sel;
    logic [1:0] mode;
  } tmb_mode_s;

  typedef struct packed {
    logic [`TMB_CNT_W-1:0] cnt;
    logic [`TMB_CNT_W-1:0] reload;
    tmb_mode_s             cfg;
    logic                  armed;
    logic                  pin_prev;
    logic                  evt;
    logic                  irq;
  } tmb_chan_s;

  typedef struct packed {
    tmb_chan_s [`TMB_NUM_CH-1:0] ch;
    logic [`TMB_NUM_CH-1:0]      start;
    logic [`TMB_DATA_W-1:0]      prdata;
    logic                        pslverr;
  } tmb_state_s;

  typedef struct packed {
    logic                     hit;
    logic                     is_start;
    logic                     is_mode;
    logic [`TMB_CH_IDX_W-1:0] ch;
  } tmb_dec_s;

  typedef struct packed {
    logic [`TMB_DIV_W-1:0] div_cnt;
    logic [`TMB_DIV_W-1:0] sub_cnt;
    logic                  sub_prev;
    logic [3:0]            tick;
  } tmb_pre_s;

endpackage

// ### hdl/tmb_prescale.sv
/*
  Prescaler: one-cycle tick enables for the undivided clock, the clock divided
  by 8 and by 32, and the subclock divided by 32.
  Assumes subclk_i is synchronous to clk_i and slower than half its rate.
*/
`timescale 1ns/1ns
`include "tmb_consts.svh"

module tmb_prescale (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       subclk_i,
  output logic      [3:0] tick_o
);

  tmb_pkg::tmb_pre_s s_q;
  tmb_pkg::tmb_pre_s s_d;
  logic              sub_rise;

  // ****************************************
  // Dividers
  // ****************************************
  always_comb
  begin
    s_d          = s_q;
    sub_rise     = subclk_i & ~s_q.sub_prev;
    s_d.sub_prev = subclk_i;
    s_d.div_cnt  = s_q.div_cnt + `TMB_DIV_ONE;
    if (sub_rise)
    begin
      s_d.sub_cnt = s_q.sub_cnt + `TMB_DIV_ONE;
    end
    s_d.tick[`TMB_CLK_DIV1]  = 1'b1;
    s_d.tick[`TMB_CLK_DIV8]  = (s_q.div_cnt & `TMB_DIV8_MASK) == `TMB_DIV8_MASK;
    s_d.tick[`TMB_CLK_DIV32] = s_q.div_cnt == `TMB_DIV32_LAST;
    s_d.tick[`TMB_CLK_SUB32] = sub_rise && (s_q.sub_cnt == `TMB_DIV32_LAST);
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

endmodule

// ### hdl/tmb_top.sv
/*
  Six-channel 16-bit timer with interval, event counting and pulse
  period/width measurement modes, reached over an APB slave.
  Assumes an APB master on clk_i, pins and subclock synchronous to clk_i.
*/
`timescale 1ns/1ns
`include "tmb_consts.svh"

module tmb_top #(
  parameter int NUM_CH = `TMB_NUM_CH
) (
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [`TMB_ADDR_W-1:0]  paddr_i,
  input  wire logic [`TMB_DATA_W-1:0]  pwdata_i,
  input  wire logic [3:0]              pstrb_i,
  output logic      [`TMB_DATA_W-1:0]  prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  input  wire logic [`TMB_NUM_CH-1:0]  timer_input_pin_i,
  input  wire logic                    subclk_i,
  output logic      [`TMB_NUM_CH-1:0]  irq_req_o,
  output logic      [`TMB_NUM_CH-1:0]  ovf_flag_o
);

  tmb_pkg::tmb_state_s s_q;
  tmb_pkg::tmb_state_s s_d;
  logic [3:0]          tick;

  // ****************************************
  // Functions
  // ****************************************
  function automatic tmb_pkg::tmb_dec_s decode(input logic [`TMB_ADDR_W-1:0] a);
    tmb_pkg::tmb_dec_s d;
    logic [`TMB_ADDR_W-1:0] idx;
    d        = '0;
    idx      = a >> `TMB_CH_SHIFT;
    d.ch     = idx[`TMB_CH_IDX_W-1:0];
    d.is_mode = a[`TMB_SEL_BIT] == `TMB_SEL_MODE;
    if (a == `TMB_START_ADDR)
    begin
      d.hit      = 1'b1;
      d.is_start = 1'b1;
    end
    else if ((a < `TMB_START_ADDR) && (a[1:0] == `TMB_ALIGN_ZERO))
    begin
      d.hit = 1'b1;
    end
    return d;
  endfunction

  function automatic logic [`TMB_DATA_W-1:0] merge(input logic [`TMB_DATA_W-1:0] old,
                                                   input logic [`TMB_DATA_W-1:0] wd,
                                                   input logic [3:0]             strb);
    logic [`TMB_DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic eff_edge(input logic [1:0] sel,
                                    input logic       prev,
                                    input logic       cur);
    logic r;
    r = 1'b0;
    unique case (sel)
      `TMB_EDGE_FALL: r = prev & ~cur;
      `TMB_EDGE_RISE: r = ~prev & cur;
      `TMB_EDGE_BOTH: r = prev ^ cur;
      default:        r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [`TMB_DATA_W-1:0] rd_value(input tmb_pkg::tmb_state_s s,
                                                      input tmb_pkg::tmb_dec_s   d);
    logic [`TMB_DATA_W-1:0] r;
    r = `TMB_RD_ZERO;
    if (d.is_start)
    begin
      r[`TMB_NUM_CH-1:0] = s.start;
    end
    else if (d.ch < `TMB_CH_IDX_W'(NUM_CH))
    begin
      if (d.is_mode)
      begin
        r[$bits(tmb_pkg::tmb_mode_s)-1:0] = s.ch[d.ch].cfg;
      end
      else if (s.ch[d.ch].cfg.mode == `TMB_MODE_MEASURE)
      begin
        r[`TMB_CNT_W-1:0] = s.ch[d.ch].reload;
      end
      else
      begin
        r[`TMB_CNT_W-1:0] = s.ch[d.ch].cnt;
      end
    end
    return r;
  endfunction

  // ****************************************
  // Prescaler
  // ****************************************
  tmb_prescale u_prescale (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .subclk_i  (subclk_i),
    .tick_o    (tick)
  );

  // ****************************************
  // Channels and register file
  // ****************************************
  always_comb
  begin
    tmb_pkg::tmb_dec_s      dec;
    tmb_pkg::tmb_chan_s     c;
    tmb_pkg::tmb_mode_s     wm;
    logic [`TMB_DATA_W-1:0] wv;
    logic                   wr;
    logic                   setup;
    logic                   run;
    logic                   src;
    logic                   ev;
    logic                   wr_timer;
    logic                   wr_mode;
    int                     prv;
    dec      = decode(paddr_i);
    c        = '0;
    wm       = '0;
    wv       = `TMB_RD_ZERO;
    run      = 1'b0;
    src      = 1'b0;
    ev       = 1'b0;
    wr_timer = 1'b0;
    wr_mode  = 1'b0;
    prv      = 0;
    s_d      = s_q;
    wr       = psel_i & penable_i & pwrite_i & dec.hit;
    setup    = psel_i & ~penable_i;

    if (setup)
    begin
      s_d.pslverr = ~dec.hit;
      s_d.prdata  = pwrite_i ? `TMB_RD_ZERO : rd_value(s_q, dec);
    end

    if (wr && dec.is_start)
    begin
      wv      = merge({{(`TMB_DATA_W-`TMB_NUM_CH){1'b0}}, s_q.start}, pwdata_i, pstrb_i);
      s_d.start = wv[`TMB_NUM_CH-1:0];
    end

    for (int i = 0; i < NUM_CH; i++)
    begin
      c        = s_q.ch[i];
      run      = s_q.start[i];
      prv      = (i == 0) ? NUM_CH - 1 : i - 1;
      wr_timer = wr && !dec.is_start && (dec.ch == `TMB_CH_IDX_W'(i)) && !dec.is_mode;
      wr_mode  = wr && !dec.is_start && (dec.ch == `TMB_CH_IDX_W'(i)) && dec.is_mode;
      s_d.ch[i].pin_prev = timer_input_pin_i[i];
      s_d.ch[i].evt      = 1'b0;
      s_d.ch[i].irq      = 1'b0;
      if (!run)
      begin
        s_d.ch[i].armed = 1'b0;
      end

      // Mode write, flag clear only while running, before any set below
      if (wr_mode)
      begin
        wv = merge({{(`TMB_DATA_W-$bits(tmb_pkg::tmb_mode_s)){1'b0}}, c.cfg}, pwdata_i, pstrb_i);
        wm = wv[$bits(tmb_pkg::tmb_mode_s)-1:0];
        s_d.ch[i].cfg.mode     = wm.mode;
        s_d.ch[i].cfg.edge_sel = wm.edge_sel;
        s_d.ch[i].cfg.ev_src   = wm.ev_src;
        s_d.ch[i].cfg.clk_sel  = wm.clk_sel;
        if (run)
        begin
          s_d.ch[i].cfg.ovf = 1'b0;
        end
      end

      // Timer register write
      if (wr_timer && (c.cfg.mode != `TMB_MODE_MEASURE))
      begin
        wv = merge({c.reload, c.reload}, pwdata_i, pstrb_i);
        s_d.ch[i].reload = wv[`TMB_CNT_W-1:0];
        if (!run)
        begin
          s_d.ch[i].cnt = wv[`TMB_CNT_W-1:0];
        end
      end

      // Count source per mode
      src = 1'b0;
      unique case (c.cfg.mode)
        `TMB_MODE_TIMER:   src = tick[c.cfg.clk_sel];
        `TMB_MODE_EVENT:
        begin
          if (c.cfg.ev_src == `TMB_SRC_CHAIN)
          begin
            src = s_q.ch[prv].evt;
          end
          else
          begin
            src = eff_edge(c.cfg.edge_sel, c.pin_prev, timer_input_pin_i[i]);
          end
        end
        `TMB_MODE_MEASURE: src = tick[c.cfg.clk_sel];
        `TMB_MODE_RSVD:    src = 1'b0;
      endcase

      if (run)
      begin
        if (c.cfg.mode == `TMB_MODE_MEASURE)
        begin
          ev = eff_edge(c.cfg.edge_sel, c.pin_prev, timer_input_pin_i[i]);
          if (ev)
          begin
            s_d.ch[i].reload = c.cnt;
            s_d.ch[i].cnt    = `TMB_CNT_ZERO;
            s_d.ch[i].armed  = 1'b1;
            s_d.ch[i].irq    = c.armed;
          end
          else if (src)
          begin
            s_d.ch[i].cnt = c.cnt + `TMB_CNT_ONE;
            if (c.cnt == `TMB_CNT_MAX)
            begin
              s_d.ch[i].cfg.ovf = 1'b1;
              s_d.ch[i].irq     = 1'b1;
              s_d.ch[i].evt     = 1'b1;
            end
          end
        end
        else if (src && (c.cfg.mode != `TMB_MODE_RSVD))
        begin
          if (c.cnt == `TMB_CNT_ZERO)
          begin
            s_d.ch[i].cnt = s_d.ch[i].reload;
            s_d.ch[i].irq = 1'b1;
            s_d.ch[i].evt = 1'b1;
          end
          else
          begin
            s_d.ch[i].cnt = c.cnt - `TMB_CNT_ONE;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pready_o  = 1'b1;
  assign prdata_o  = s_q.prdata;
  assign pslverr_o = s_q.pslverr;

  always_comb
  begin
    for (int i = 0; i < `TMB_NUM_CH; i++)
    begin
      irq_req_o[i]  = s_q.ch[i].irq;
      ovf_flag_o[i] = s_q.ch[i].cfg.ovf;
    end
  end

endmodule

// ### testbench/tmb_top_assertions.sv
/*
  Checker of the timer block: APB answers, stop and overflow flag behaviour.
  Assumes it is bound to tmb_top and sees only that module's ports.
*/
`timescale 1ns/1ns
`include "tmb_consts.svh"

module tmb_top_assertions #(
  parameter int NUM_CH = `TMB_NUM_CH
) (
  input wire logic                   clk_i,
  input wire logic                   sys_rst_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [`TMB_ADDR_W-1:0] paddr_i,
  input wire logic [`TMB_DATA_W-1:0] pwdata_i,
  input wire logic [3:0]             pstrb_i,
  input wire logic [`TMB_DATA_W-1:0] prdata_o,
  input wire logic                   pready_o,
  input wire logic                   pslverr_o,
  input wire logic [`TMB_NUM_CH-1:0] timer_input_pin_i,
  input wire logic                   subclk_i,
  input wire logic [`TMB_NUM_CH-1:0] irq_req_o,
  input wire logic [`TMB_NUM_CH-1:0] ovf_flag_o
);
  logic [`TMB_NUM_CH-1:0] start_q;
  logic                   setup;
  logic                   wr_acc;
  logic                   bad;
  logic                   mode4_wr;
  assign setup    = psel_i & ~penable_i;
  assign wr_acc   = psel_i & penable_i & pwrite_i;
  assign bad      = (paddr_i > `TMB_START_ADDR) || (paddr_i[1:0] != 2'b00);
  assign mode4_wr = wr_acc && (paddr_i == 8'h24) && start_q[4];

  // Shadow of the start flags
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      start_q <= '0;
    else if (wr_acc && paddr_i == `TMB_START_ADDR && pstrb_i[0])
      start_q <= pwdata_i[`TMB_NUM_CH-1:0];
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ****************************************
  // Properties
  // ****************************************
  sequence s_stopped;
    !start_q[0] [*4];
  endsequence
  property p_ready;
    pready_o;
  endproperty
  property p_err_bad;
    setup && bad |=> pslverr_o;
  endproperty
  property p_rd_zero;
    setup && bad && !pwrite_i |=> prdata_o == 32'h0000_0000;
  endproperty
  property p_err_ok;
    setup && !bad |=> !pslverr_o;
  endproperty
  property p_tmr_hi;
    setup && !pwrite_i && paddr_i < `TMB_START_ADDR && paddr_i[2:0] == 3'h0 |=> prdata_o[31:16] == 16'h0000;
  endproperty
  property p_stop;
    s_stopped |-> !irq_req_o[0];
  endproperty
  property p_ovf_irq;
    $rose(ovf_flag_o[4]) |-> ##[0:1] irq_req_o[4] or $past(irq_req_o[4]);
  endproperty
  property p_ovf_clr;
    $fell(ovf_flag_o[4]) |-> $past(mode4_wr);
  endproperty

  a_ready: assert property (p_ready) else $error("pready low");
  a_err_bad: assert property (p_err_bad) else $error("no error on unmapped address");
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
  a_err_ok: assert property (p_err_ok) else $error("error on mapped address");
  a_tmr_hi: assert property (p_tmr_hi) else $error("timer read upper bits set");
  a_stop: assert property (p_stop) else $error("interrupt while stopped");
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow without interrupt");
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag cleared without cause");
endmodule

bind tmb_top tmb_top_assertions #(.NUM_CH(NUM_CH)) i_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .timer_input_pin_i(timer_input_pin_i), .subclk_i(subclk_i),
  .irq_req_o(irq_req_o), .ovf_flag_o(ovf_flag_o));

// ### testbench/tmb_pulse_src.sv
/*
  Partner: external pulse source on the timer input pin.
  Assumes go_i is a one-cycle request; the pin rests low between bursts.
*/
`timescale 1ns/1ns

module tmb_pulse_src (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] num_i,
  input  wire logic [7:0] half_i,
  output logic            pin_o,
  output logic            busy_o
);
  logic [8:0] left;
  logic [7:0] t;
  initial pin_o = 1'b0;
  initial left = 9'h0;
  assign busy_o = (left != 9'h0);

  // Plain port level, toggled each half period
  always @(posedge clk_i)
  begin
    if (go_i)
    begin
      left <= {num_i, 1'b0};
      t    <= half_i;
    end
    else if (left != 9'h0)
    begin
      if (t == 8'h1)
      begin
        pin_o <= ~pin_o;
        left  <= left - 9'h1;
        t     <= half_i;
      end
      else
        t <= t - 8'h1;
    end
  end
endmodule

// ### testbench/test_tmb_top.sv
/*
  Self-checking bench of the six-channel timer over APB.
  Assumes tmb_top, the pulse source and the checker are compiled first.
*/
`timescale 1ns/1ns
`include "tmb_consts.svh"

module test_tmb_top;
  logic        clk_i;
  logic        sys_rst_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        src_go;
  logic [7:0]  src_num;
  logic [7:0]  src_half;
  logic        src_pin;
  logic        src_busy;
  logic [1:0]  sc_cnt = 2'b00;
  logic [5:0]  irq;
  logic [5:0]  ovf;
  logic [31:0] rd;
  logic        err;
  int          irq_cnt [6] = '{default: 0};
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          c0;
  int          tn [4] = '{2, 1, 0, 0};
  int          tw [4] = '{30, 64, 64, 256};
  int          tx [4] = '{10, 4, 2, 2};
  int          ex [3] = '{2, 2, 4};

  tmb_top #(.NUM_CH(6)) i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .timer_input_pin_i({6{src_pin}}), .subclk_i(sc_cnt[1]), .irq_req_o(irq), .ovf_flag_o(ovf));
  tmb_pulse_src i_src (.clk_i(clk_i), .go_i(src_go), .num_i(src_num), .half_i(src_half),
    .pin_o(src_pin), .busy_o(src_busy));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    sc_cnt <= sc_cnt + 2'h1;
    for (int k = 0; k < 6; k++)
      irq_cnt[k] <= irq_cnt[k] + int'(irq[k]);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1)
      @(posedge clk_i);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  task automatic irq_win(input int ch, input int win, input int exp);
    c0 = irq_cnt[ch];
    repeat (win) @(posedge clk_i);
    chk("irq count", 32'(irq_cnt[ch] - c0), 32'(exp));
  endtask

  task automatic pulse(input logic [7:0] n, input logic [7:0] h);
    @(posedge clk_i);
    src_num  <= n;
    src_half <= h;
    src_go   <= 1'b1;
    @(posedge clk_i);
    src_go   <= 1'b0;
    repeat (2) @(posedge clk_i);
    while (src_busy)
      @(posedge clk_i);
    repeat (4) @(posedge clk_i);
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h0;
    pwdata    = 32'h0;
    pstrb     = 4'hF;
    src_go    = 1'b0;
    src_num   = 8'h0;
    src_half  = 8'h1;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdchk("mode reset", 8'h04, 32'h0);
    rdchk("timer reset", 8'h00, 32'h0);
    xfer(1'b0, 8'h34, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    xfer(1'b1, 8'h02, 32'h7);
    chk("misaligned err", 32'(err), 32'h1);
    xfer(1'b1, 8'h00, 32'h5);
    rdchk("stopped load", 8'h00, 32'h5);
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, 8'h30, 32'h0);
      xfer(1'b1, 8'h04, 32'(k * 64));
      xfer(1'b1, 8'h00, 32'(tn[k]));
      xfer(1'b1, 8'h30, 32'h1);
      repeat (tw[k]) @(posedge clk_i);
      irq_win(0, tw[k], tx[k]);
    end
    xfer(1'b1, 8'h30, 32'h0);
    xfer(1'b1, 8'h04, 32'h0);
    xfer(1'b1, 8'h00, 32'h2);
    xfer(1'b1, 8'h30, 32'h1);
    xfer(1'b1, 8'h00, 32'h4);
    repeat (12) @(posedge clk_i);
    irq_win(0, 50, 10);
    xfer(1'b1, 8'h30, 32'h0);
    repeat (2) @(posedge clk_i);
    irq_win(0, 40, 0);
    xfer(1'b1, 8'h28, 32'h0);
    xfer(1'b1, 8'h2C, 32'h3);
    xfer(1'b1, 8'h30, 32'h20);
    irq_win(5, 40, 0);
    for (int e = 0; e < 3; e++)
    begin
      xfer(1'b1, 8'h30, 32'h0);
      xfer(1'b1, 8'h0C, 32'(e * 4 + 1));
      xfer(1'b1, 8'h08, 32'h1);
      xfer(1'b1, 8'h30, 32'h2);
      c0 = irq_cnt[1];
      pulse(8'h4, 8'h3);
      chk("event irq", 32'(irq_cnt[1] - c0), 32'(ex[e]));
    end
    xfer(1'b1, 8'h30, 32'h0);
    xfer(1'b1, 8'h0C, 32'h0);
    xfer(1'b1, 8'h08, 32'h2);
    xfer(1'b1, 8'h14, 32'h11);
    xfer(1'b1, 8'h10, 32'h1);
    xfer(1'b1, 8'h30, 32'h6);
    repeat (60) @(posedge clk_i);
    irq_win(2, 60, 10);
    xfer(1'b1, 8'h30, 32'h0);
    xfer(1'b1, 8'h1C, 32'h6);
    xfer(1'b1, 8'h30, 32'h8);
    c0 = irq_cnt[3];
    pulse(8'h4, 8'hA);
    chk("measure irq", 32'(irq_cnt[3] - c0), 32'h3);
    rdchk("period", 8'h18, 32'h13);
    xfer(1'b1, 8'h18, 32'h0000_1234);
    rdchk("no write", 8'h18, 32'h13);
    xfer(1'b1, 8'h30, 32'h0);
    xfer(1'b1, 8'h20, 32'h0000_FFF0);
    xfer(1'b1, 8'h24, 32'h2);
    xfer(1'b1, 8'h30, 32'h10);
    c0 = 0;
    while (ovf[4] !== 1'b1 && c0 < 100)
    begin
      @(posedge clk_i);
      c0++;
    end
    chk("ovf set", 32'(ovf[4]), 32'h1);
    xfer(1'b1, 8'h30, 32'h0);
    xfer(1'b1, 8'h24, 32'h2);
    @(posedge clk_i);
    chk("ovf kept", 32'(ovf[4]), 32'h1);
    xfer(1'b1, 8'h30, 32'h10);
    xfer(1'b1, 8'h24, 32'h2);
    @(posedge clk_i);
    chk("ovf clear", 32'(ovf[4]), 32'h0);
    report_and_stop();
  end
endmodule
